// *** core/switch_route_pkg.sv ***
// Shared constants and types for the switch packet and event routing core
package switch_route_pkg;
	localparam int NPORTS = 4;
	localparam int PW = 2;
	localparam int TAGS = 32;
	localparam int TW = 5;
	localparam int STW = 11;

	// Register map: per-port block at port*16, global block above
	localparam logic [7:0] PORT_STRIDE = 8'h10;
	localparam logic [3:0] OFF_CFG = 4'h0;
	localparam logic [3:0] OFF_STATUS = 4'h4;
	localparam logic [7:0] ADDR_OUTSTANDING = 8'h40;

	// Config word fields
	localparam int CF_MASK = 0;
	localparam int CF_DEF = 4;
	localparam int CF_PRIM = 6;
	localparam int CF_MAMODE = 7;
	localparam int CF_SERR_BR = 8;
	localparam int CF_SERR_CMD = 9;
	localparam int CF_SLAVE = 10;
	localparam int CF_UNIT = 11;

	// Status word bits: primary status, secondary status, link error
	localparam int ST_RMA = 0;
	localparam int ST_RTA = 1;
	localparam int ST_STA = 2;
	localparam int ST_SSE = 3;
	localparam int SS_RMA = 4;
	localparam int SS_RTA = 5;
	localparam int SS_STA = 6;
	localparam int SS_RSE = 7;
	localparam int LE_EOC = 8;
	localparam int LE_HIEOC = 9;
	localparam int LE_RSPERR = 10;

	localparam logic [NPORTS-1:0] PRIMARY_RST = 4'h1;
	localparam logic [NPORTS-1:0] PMASK_RST = 4'hf;
	localparam logic [PW-1:0] DEFPORT_RST = 2'h0;

	typedef enum logic [2:0] {
		K_NPREQ = 3'b000,
		K_FLUSH = 3'b001,
		K_FENCE = 3'b010,
		K_RESP = 3'b011,
		K_BCAST = 3'b100,
		K_SYNC = 3'b101,
		K_RESET = 3'b110
	} pkt_kind_e;

	typedef struct packed {
		logic [PW-1:0] port;
		pkt_kind_e     kind;
		logic [TW-1:0] srcTag;
		logic [3:0]    seqId;
		logic [4:0]    unitId;
		logic          bridge;
		logic          err;
		logic          tgtAbort;
		logic          warm;
		logic [PW-1:0] dest;
		logic [31:0]   data;
	} pkt_s;

	typedef struct packed {
		logic          valid;
		logic [TW-1:0] origTag;
		logic [3:0]    seqId;
		logic [4:0]    unitId;
		logic [PW-1:0] port;
	} ost_s;

	// Field order matches the config word, most significant field first
	typedef struct packed {
		logic [4:0]        unitId;
		logic              actAsSlave;
		logic              serrCmd;
		logic              serrBridge;
		logic              maMode;
		logic              primary;
		logic [PW-1:0]     defPort;
		logic [NPORTS-1:0] mask;
	} port_cfg_s;
endpackage

// *** core/switch_packet_router.sv ***
// Packet and event routing core with outstanding request table
`timescale 1ns/1ps

module switch_packet_router (
	input  wire logic                                    ref_clk,
	input  wire logic                                    srst,
	input  wire logic                                    inValid,
	input  wire switch_route_pkg::pkt_s                  inPkt,
	output logic                                         inReady,
	output logic                                         outValid,
	output logic [switch_route_pkg::NPORTS-1:0]          outMask,
	output switch_route_pkg::pkt_s                       outPkt,
	output logic [switch_route_pkg::NPORTS-1:0]          floodMask,
	output logic [switch_route_pkg::NPORTS-1:0]          resetMask,
	output logic                                         resetWarm,
	output logic [switch_route_pkg::NPORTS-1:0]          secIfReset,
	input  wire logic [7:0]                              regAddr,
	input  wire logic [31:0]                             regWdata,
	input  wire logic                                    regWr,
	input  wire logic                                    regRd,
	output logic [31:0]                                  regRdata
);
	localparam int N = switch_route_pkg::NPORTS;
	localparam int PW = switch_route_pkg::PW;
	localparam int TW = switch_route_pkg::TW;
	localparam int STW = switch_route_pkg::STW;

	switch_route_pkg::port_cfg_s cfg [N];
	logic [STW-1:0]              status [N];
	switch_route_pkg::ost_s      table_q [switch_route_pkg::TAGS];

	////////////////////////////////////////////////////////////////////////
	// Partition and lookup helpers

	function automatic logic samePart(input logic [PW-1:0] a, input logic [PW-1:0] b);
		samePart = cfg[a].mask[b] && cfg[b].mask[a];
	endfunction

	function automatic logic [N-1:0] partSecondaries(input logic [PW-1:0] a);
		partSecondaries = '0;
		for (int q = 0; q < N; q++) begin
			partSecondaries[q] = samePart(a, PW'(q)) && !cfg[q].primary;
		end
	endfunction

	function automatic logic [N-1:0] oneHot(input logic [PW-1:0] p);
		oneHot = N'(1) << p;
	endfunction

	logic [N-1:0] primaryBits;
	logic [N-1:0] slaveBits;
	always_comb begin
		for (int q = 0; q < N; q++) begin
			primaryBits[q] = cfg[q].primary;
			slaveBits[q] = cfg[q].actAsSlave;
		end
	end

	// First free table slot; its index becomes the reassigned tag
	logic          tableFull;
	logic [TW-1:0] freeIdx;
	always_comb begin
		tableFull = 1'b1;
		freeIdx = '0;
		for (int i = switch_route_pkg::TAGS - 1; i >= 0; i--) begin
			if (!table_q[i].valid) begin
				tableFull = 1'b0;
				freeIdx = TW'(i);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Routing decision

	logic                     inFire;
	logic                     up;
	logic [PW-1:0]            ing;
	switch_route_pkg::ost_s   hit;
	logic                     respOk;
	logic                     next_outValid;
	logic [N-1:0]             next_outMask;
	switch_route_pkg::pkt_s   next_outPkt;
	logic [N-1:0]             next_flood;
	logic [N-1:0]             next_reset;
	logic [N-1:0]             next_secReset;
	logic                     alloc;
	logic                     release_;
	logic [STW-1:0]           stSet [N];

	// Every packet waits while no tag is free, except the cycle after a last free slot other than 31 is taken
	assign inFire = inValid && inReady;
	assign ing = inPkt.port;
	assign up = !cfg[inPkt.port].primary;
	assign hit = table_q[inPkt.srcTag];

	always_comb begin
		logic [PW-1:0] e;
		logic          ma;
		logic          ta;
		e = hit.port;
		ma = inPkt.err && !inPkt.tgtAbort;
		ta = inPkt.err && inPkt.tgtAbort;
		next_outValid = 1'b0;
		next_outMask = '0;
		next_outPkt = inPkt;
		next_flood = '0;
		next_reset = '0;
		next_secReset = '0;
		alloc = 1'b0;
		release_ = 1'b0;
		respOk = 1'b0;
		for (int q = 0; q < N; q++) begin
			stSet[q] = '0;
		end
		if (inFire) begin
			unique case (inPkt.kind)
				switch_route_pkg::K_NPREQ: begin
					// Primary to primary never forwarded
					if (samePart(ing, inPkt.dest) &&
							!(cfg[ing].primary && cfg[inPkt.dest].primary)) begin
						alloc = 1'b1;
						next_outValid = 1'b1;
						next_outMask = oneHot(inPkt.dest);
						next_outPkt.srcTag = freeIdx;
					end
				end
				switch_route_pkg::K_FLUSH, switch_route_pkg::K_FENCE: begin
					if (up) begin
						if (samePart(ing, cfg[ing].defPort)) begin
							next_outValid = 1'b1;
							next_outMask = oneHot(cfg[ing].defPort);
						end
					end else if (inPkt.kind == switch_route_pkg::K_FLUSH) begin
						next_outValid = 1'b1;
						next_outMask = oneHot(ing);
						next_outPkt.kind = switch_route_pkg::K_RESP;
						next_outPkt.err = 1'b1;
						next_outPkt.tgtAbort = 1'b0;
					end else begin
						stSet[ing][switch_route_pkg::LE_EOC] = 1'b1;
					end
				end
				switch_route_pkg::K_RESP: begin
					if (up && inPkt.bridge) begin
						stSet[ing][switch_route_pkg::LE_HIEOC] = 1'b1;
					end else if (!up && (!inPkt.bridge || inPkt.unitId != cfg[ing].unitId)) begin
						stSet[ing][switch_route_pkg::LE_EOC] = 1'b1;
					end else if (!hit.valid) begin
						stSet[ing][switch_route_pkg::LE_RSPERR] = 1'b1;
					end else begin
						respOk = 1'b1;
						release_ = 1'b1;
						next_outValid = 1'b1;
						next_outMask = oneHot(e);
						next_outPkt.srcTag = hit.origTag;
						next_outPkt.seqId = hit.seqId;
						next_outPkt.unitId = hit.unitId;
						if (up && e != ing && (ta || (ma && cfg[ing].maMode))) begin
							if (cfg[e].primary) begin
								stSet[e][switch_route_pkg::SS_RTA] = 1'b1;
								stSet[e][switch_route_pkg::ST_STA] = 1'b1;
							end else begin
								stSet[e][switch_route_pkg::ST_RTA] = 1'b1;
								stSet[e][switch_route_pkg::SS_STA] = 1'b1;
							end
						end
						if (up && e != ing && ma) begin
							stSet[ing][switch_route_pkg::SS_RMA] = 1'b1;
							if (cfg[ing].maMode) begin
								stSet[ing][switch_route_pkg::ST_STA] = 1'b1;
								next_outPkt.tgtAbort = 1'b1;
							end else begin
								next_outPkt.err = 1'b0;
							end
						end
						if (up && e != ing && ta) begin
							stSet[ing][switch_route_pkg::SS_RTA] = 1'b1;
							stSet[ing][switch_route_pkg::ST_STA] = 1'b1;
						end
						if (!up && ma) begin
							stSet[ing][switch_route_pkg::ST_RMA] = 1'b1;
							if (cfg[ing].maMode) begin
								stSet[ing][switch_route_pkg::SS_STA] = 1'b1;
								stSet[e][switch_route_pkg::ST_RTA] = 1'b1;
								stSet[e][switch_route_pkg::SS_STA] = 1'b1;
								next_outPkt.tgtAbort = 1'b1;
							end else begin
								next_outPkt.err = 1'b0;
							end
						end
						if (!up && ta) begin
							stSet[ing][switch_route_pkg::ST_RTA] = 1'b1;
							stSet[ing][switch_route_pkg::SS_STA] = 1'b1;
							stSet[e][switch_route_pkg::ST_RTA] = 1'b1;
							stSet[e][switch_route_pkg::SS_STA] = 1'b1;
						end
					end
				end
				switch_route_pkg::K_BCAST: begin
					if (!up) begin
						next_outMask = partSecondaries(ing);
						next_outValid = |next_outMask;
					end
				end
				switch_route_pkg::K_SYNC: begin
					if (!up) begin
						next_flood = partSecondaries(ing);
					end else begin
						next_flood[ing] = 1'b1;
						stSet[ing][switch_route_pkg::SS_RSE] = 1'b1;
						if (cfg[ing].serrBridge && cfg[ing].serrCmd) begin
							stSet[ing][switch_route_pkg::ST_SSE] = 1'b1;
							for (int q = 0; q < N; q++) begin
								if (samePart(ing, PW'(q))) begin
									if (cfg[q].primary) begin
										stSet[q][switch_route_pkg::SS_RSE] = 1'b1;
										if (cfg[q].serrBridge && cfg[q].serrCmd) begin
											next_flood[q] = 1'b1;
											stSet[q][switch_route_pkg::ST_SSE] = 1'b1;
										end
									end else begin
										next_flood[q] = 1'b1;
									end
								end
							end
						end
					end
				end
				switch_route_pkg::K_RESET: begin
					if (!up) begin
						next_reset = partSecondaries(ing);
					end else begin
						next_secReset[ing] = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			outValid <= 1'b0;
			outMask <= '0;
			outPkt <= '0;
			floodMask <= '0;
			resetMask <= '0;
			resetWarm <= 1'b0;
			secIfReset <= '0;
		end else begin
			outValid <= next_outValid;
			outMask <= next_outMask;
			outPkt <= next_outPkt;
			floodMask <= next_flood;
			resetMask <= next_reset;
			resetWarm <= inPkt.warm && (|next_reset);
			secIfReset <= next_secReset;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			inReady <= 1'b0;
		end else begin
			inReady <= !tableFull && !(alloc && freeIdx == TW'(switch_route_pkg::TAGS - 1));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outstanding request table

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			for (int i = 0; i < switch_route_pkg::TAGS; i++) begin
				table_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < switch_route_pkg::TAGS; i++) begin
				if (|next_secReset && table_q[i].valid && next_secReset[table_q[i].port]) begin
					table_q[i].valid <= 1'b0;
				end
			end
			if (release_) begin
				table_q[inPkt.srcTag].valid <= 1'b0;
			end
			if (alloc) begin
				table_q[freeIdx] <= '{valid: 1'b1, origTag: inPkt.srcTag, seqId: inPkt.seqId,
					unitId: inPkt.unitId, port: ing};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register port

	logic [5:0] outstanding;
	always_comb begin
		outstanding = '0;
		for (int i = 0; i < switch_route_pkg::TAGS; i++) begin
			outstanding = outstanding + 6'(table_q[i].valid);
		end
	end

	logic          selPort;
	logic [PW-1:0] regPort;
	assign selPort = regAddr < 8'(N * switch_route_pkg::PORT_STRIDE);
	assign regPort = regAddr[5:4];

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			for (int q = 0; q < N; q++) begin
				cfg[q] <= '{mask: switch_route_pkg::PMASK_RST, defPort: switch_route_pkg::DEFPORT_RST,
					primary: switch_route_pkg::PRIMARY_RST[q], default: '0};
			end
		end else if (regWr && selPort && regAddr[3:0] == switch_route_pkg::OFF_CFG) begin
			cfg[regPort] <= regWdata[switch_route_pkg::CF_UNIT+4:0];
			// Secondary ports cannot act as slave
			cfg[regPort].actAsSlave <= regWdata[switch_route_pkg::CF_SLAVE] &&
				regWdata[switch_route_pkg::CF_PRIM];
		end
	end

	// Write one to clear; a set in the same cycle wins
	always_ff @(posedge ref_clk) begin
		for (int q = 0; q < N; q++) begin
			if (srst) begin
				status[q] <= '0;
			end else if (regWr && selPort && regPort == PW'(q) &&
					regAddr[3:0] == switch_route_pkg::OFF_STATUS) begin
				status[q] <= (status[q] & ~regWdata[STW-1:0]) | stSet[q];
			end else begin
				status[q] <= status[q] | stSet[q];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			regRdata <= '0;
		end else if (regRd && selPort && regAddr[3:0] == switch_route_pkg::OFF_CFG) begin
			regRdata <= 32'(cfg[regPort]);
		end else if (regRd && selPort && regAddr[3:0] == switch_route_pkg::OFF_STATUS) begin
			regRdata <= 32'(status[regPort]);
		end else if (regRd && regAddr == switch_route_pkg::ADDR_OUTSTANDING) begin
			regRdata <= 32'(outstanding);
		end else begin
			regRdata <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	AST_BCAST_SECONDARY: assert property (
		outValid && outPkt.kind == switch_route_pkg::K_BCAST |-> (outMask & primaryBits) == '0)
		else $error("broadcast reached a primary port");
	AST_UP_BCAST_DROP: assert property (
		inFire && up && inPkt.kind == switch_route_pkg::K_BCAST |=> !outValid)
		else $error("upstream broadcast forwarded");
	AST_DN_FENCE_EOC: assert property (
		inFire && !up && inPkt.kind == switch_route_pkg::K_FENCE
		|=> !outValid && status[$past(ing)][switch_route_pkg::LE_EOC])
		else $error("downstream fence not dropped with end-of-chain");
	AST_SLAVE_ZERO: assert property ((slaveBits & ~primaryBits) == '0)
		else $error("secondary port acts as slave");
	AST_DN_FLUSH_MA: assert property (
		inFire && !up && inPkt.kind == switch_route_pkg::K_FLUSH
		|=> outValid && outPkt.kind == switch_route_pkg::K_RESP && outPkt.err && !outPkt.tgtAbort)
		else $error("downstream flush not master aborted");
	AST_UNMATCHED: assert property (
		inFire && inPkt.kind == switch_route_pkg::K_RESP && !hit.valid |=> !outValid)
		else $error("unmatched response forwarded");
	AST_UP_RESET_LOCAL: assert property (
		inFire && up && inPkt.kind == switch_route_pkg::K_RESET
		|=> secIfReset == oneHot($past(ing)) && resetMask == '0)
		else $error("upstream reset not kept local");
	AST_DATA_KEPT: assert property (respOk |=> outValid && outPkt.data == $past(inPkt.data))
		else $error("response data altered");
	AST_ENTRY_FREED: assert property (respOk |=> !table_q[$past(inPkt.srcTag)].valid)
		else $error("table entry kept after response");
	AST_DN_SYNC_NOFLAG: assert property (
		inFire && !up && inPkt.kind == switch_route_pkg::K_SYNC
		|-> stSet[ing] == '0 ##1 (floodMask & primaryBits) == '0)
		else $error("downstream sync flood touched flags or primaries");

	COV_RESP_FWD: cover property (respOk ##1 outValid);
	COV_UP_SYNC: cover property (inFire && up && inPkt.kind == switch_route_pkg::K_SYNC);
	COV_TABLE_FULL: cover property (!inReady);
endmodule

// *** tb/link_agent.sv ***
// Far-side link model: offers one packet at a time and captures the answer
`timescale 1ns/1ps
module link_agent (
	input  wire logic                   ref_clk,
	input  wire logic                   inReady,
	input  wire logic                   outValid,
	input  wire logic [3:0]             outMask,
	input  wire switch_route_pkg::pkt_s outPkt,
	input  wire logic [3:0]             floodMask,
	input  wire logic [3:0]             resetMask,
	input  wire logic                   resetWarm,
	input  wire logic [3:0]             secIfReset,
	output logic                        inValid,
	output switch_route_pkg::pkt_s      inPkt
);
	logic                   got;
	logic [3:0]             gotMask;
	switch_route_pkg::pkt_s gotPkt;
	logic [11:0]            gotEvt;
	logic                   gotWarm;

	initial begin
		inValid = 1'b0;
		inPkt = '0;
	end

	task automatic send(input switch_route_pkg::pkt_s p, input int gap);
		repeat (gap) @(posedge ref_clk);
		@(posedge ref_clk);
		inValid <= 1'b1;
		inPkt <= p;
		do @(posedge ref_clk); while (inReady !== 1'b1);
		inValid <= 1'b0;
		// Released lines must not echo the last packet
		inPkt <= ~p;
		#1;
		got = outValid;
		gotMask = outMask;
		gotPkt = outPkt;
		gotEvt = {secIfReset, resetMask, floodMask};
		gotWarm = resetWarm;
	endtask
endmodule

// *** tb/switch_packet_event_routing_tb.sv ***
// Self-checking bench for the packet and event routing core
`timescale 1ns/1ps
module switch_packet_event_routing_tb;
	logic                   ref_clk;
	logic                   srst;
	logic                   inValid;
	logic                   inReady;
	logic                   outValid;
	logic [3:0]             outMask;
	switch_route_pkg::pkt_s inPkt;
	switch_route_pkg::pkt_s outPkt;
	logic [3:0]             floodMask;
	logic [3:0]             resetMask;
	logic                   resetWarm;
	logic [3:0]             secIfReset;
	logic [7:0]             regAddr;
	logic [31:0]            regWdata;
	logic                   regWr;
	logic                   regRd;
	logic [31:0]            regRdata;
	int                     errorCnt;
	int                     numChecks;
	int                     cycles;

	switch_packet_router DUT (.ref_clk(ref_clk), .srst(srst), .inValid(inValid), .inPkt(inPkt),
		.inReady(inReady), .outValid(outValid), .outMask(outMask), .outPkt(outPkt),
		.floodMask(floodMask), .resetMask(resetMask), .resetWarm(resetWarm),
		.secIfReset(secIfReset), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata));

	link_agent agent (.ref_clk(ref_clk), .inReady(inReady), .outValid(outValid),
		.outMask(outMask), .outPkt(outPkt), .floodMask(floodMask), .resetMask(resetMask),
		.resetWarm(resetWarm), .secIfReset(secIfReset), .inValid(inValid), .inPkt(inPkt));

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic endSim();
		$display("checks %0d errors %0d", numChecks, errorCnt);
		if (errorCnt == 0 && numChecks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Whole run needs a few hundred cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errorCnt++;
			endSim();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		numChecks++;
		if (got !== exp) begin
			errorCnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask

	// Reads a port's status, then clears it so each check starts clean
	task automatic chk_st(input logic [1:0] p, input logic [31:0] exp);
		logic [31:0] d;
		reg_rd({2'h0, p, 4'h4}, d);
		chk("status", exp, d);
		reg_wr({2'h0, p, 4'h4}, 32'h000007ff);
	endtask

	task automatic chk_cnt(input logic [31:0] exp);
		logic [31:0] d;
		reg_rd(8'h40, d);
		chk("outstanding", exp, d);
	endtask

	task automatic chk_out(input logic v, input logic [3:0] m);
		chk("outValid", {31'h0, v}, {31'h0, agent.got});
		if (v) begin
			chk("outMask", {28'h0, m}, {28'h0, agent.gotMask});
		end
	endtask

	task automatic chk_ev(input logic [11:0] exp);
		chk("events", {20'h0, exp}, {20'h0, agent.gotEvt});
	endtask

	task automatic chk_rsp(input logic [4:0] tag, input logic e, input logic ta,
			input logic [31:0] d);
		chk("rspHead", {24'h0, switch_route_pkg::K_RESP, tag},
			{24'h0, agent.gotPkt.kind, agent.gotPkt.srcTag});
		chk("rspFlags", {30'h0, e, ta}, {30'h0, agent.gotPkt.err, agent.gotPkt.tgtAbort});
		chk("rspData", d, agent.gotPkt.data);
	endtask

	function automatic switch_route_pkg::pkt_s mk(input logic [1:0] port,
			input switch_route_pkg::pkt_kind_e k, input logic [1:0] dst, input logic [4:0] tag,
			input logic [2:0] f, input logic [31:0] d);
		mk = '0;
		mk.port = port;
		mk.kind = k;
		mk.dest = dst;
		mk.srcTag = tag;
		mk.seqId = 4'h3;
		{mk.bridge, mk.err, mk.tgtAbort} = f;
		mk.data = d;
	endfunction

	// Request src to dst, then an error response from dst back
	task automatic round(input logic [1:0] src, input logic [1:0] dst, input logic ta,
			input logic e, input logic eta);
		agent.send(mk(src, switch_route_pkg::K_NPREQ, dst, 5'h0b, 3'h0, 32'h0), 0);
		chk_out(1'b1, 4'(1 << dst));
		agent.send(mk(dst, switch_route_pkg::K_RESP, 2'h0, agent.gotPkt.srcTag,
			{dst == 2'h0, 1'b1, ta}, 32'h5a5a0f0f), 1);
		chk_out(1'b1, 4'(1 << src));
		chk_rsp(5'h0b, e, eta, 32'h5a5a0f0f);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [31:0] d;
		reg_rd(8'h00, d);
		chk("cfg0", 32'h0000004f, d);
		reg_wr(8'h00, 32'h0000044f);
		reg_rd(8'h00, d);
		chk("cfg0Slave", 32'h0000044f, d);
		reg_wr(8'h00, 32'h0000004f);
		reg_wr(8'h10, 32'h0000040f);
		reg_rd(8'h10, d);
		chk("cfg1", 32'h0000000f, d);
		reg_wr(8'h80, 32'hffffffff);
		reg_rd(8'h80, d);
		chk("unmapped", 32'h0, d);
	endtask

	task automatic t_table();
		logic [4:0]             tag;
		switch_route_pkg::pkt_s p;
		agent.send(mk(2'h1, switch_route_pkg::K_NPREQ, 2'h0, 5'h17, 3'h0, 32'h0), 0);
		chk_out(1'b1, 4'h1);
		tag = agent.gotPkt.srcTag;
		chk("newTag", 32'h0, {27'h0, tag});
		chk_cnt(32'h1);
		// Response carries a different sequence id; the recorded one must return
		p = mk(2'h0, switch_route_pkg::K_RESP, 2'h0, tag, 3'h4, 32'hdeadbeef);
		p.seqId = 4'h9;
		agent.send(p, 2);
		chk_out(1'b1, 4'h2);
		chk_rsp(5'h17, 1'b0, 1'b0, 32'hdeadbeef);
		chk("seqId", 32'h3, {28'h0, agent.gotPkt.seqId});
		chk_cnt(32'h0);
		agent.send(mk(2'h0, switch_route_pkg::K_RESP, 2'h0, tag, 3'h4, 32'h0), 0);
		chk_out(1'b0, 4'h0);
		chk_st(2'h0, 32'h400);
	endtask

	task automatic t_reset();
		switch_route_pkg::pkt_s p;
		p = mk(2'h0, switch_route_pkg::K_RESET, 2'h0, 5'h0, 3'h0, 32'h0);
		p.warm = 1'b1;
		agent.send(p, 0);
		chk_ev(12'h0e0);
		chk("warm", 32'h1, {31'h0, agent.gotWarm});
		p.warm = 1'b0;
		agent.send(p, 0);
		chk_ev(12'h0e0);
		chk("warm", 32'h0, {31'h0, agent.gotWarm});
		// Request entering the port that is reset must be dropped from the table
		agent.send(mk(2'h3, switch_route_pkg::K_NPREQ, 2'h0, 5'h1, 3'h0, 32'h0), 0);
		chk_cnt(32'h1);
		agent.send(mk(2'h3, switch_route_pkg::K_RESET, 2'h0, 5'h0, 3'h0, 32'h0), 0);
		chk_ev(12'h800);
		chk_out(1'b0, 4'h0);
		chk_cnt(32'h0);
	endtask

	task automatic t_flush();
		agent.send(mk(2'h0, switch_route_pkg::K_FLUSH, 2'h0, 5'h2, 3'h0, 32'h0), 0);
		chk_out(1'b1, 4'h1);
		chk("maReply", {27'h0, switch_route_pkg::K_RESP, 2'h2},
			{27'h0, agent.gotPkt.kind, agent.gotPkt.err, agent.gotPkt.tgtAbort});
		agent.send(mk(2'h2, switch_route_pkg::K_FLUSH, 2'h0, 5'h2, 3'h0, 32'h0), 0);
		chk_out(1'b1, 4'h1);
		agent.send(mk(2'h1, switch_route_pkg::K_FENCE, 2'h0, 5'h2, 3'h0, 32'h0), 0);
		chk_out(1'b1, 4'h1);
		agent.send(mk(2'h0, switch_route_pkg::K_FENCE, 2'h0, 5'h2, 3'h0, 32'h0), 0);
		chk_out(1'b0, 4'h0);
		chk_st(2'h0, 32'h100);
	endtask

	task automatic t_bcast();
		agent.send(mk(2'h0, switch_route_pkg::K_BCAST, 2'h0, 5'h0, 3'h0, 32'h0), 0);
		chk_out(1'b1, 4'he);
		reg_wr(8'h30, 32'h00000006);
		agent.send(mk(2'h0, switch_route_pkg::K_BCAST, 2'h0, 5'h0, 3'h0, 32'h0), 0);
		chk_out(1'b1, 4'h6);
		reg_wr(8'h30, 32'h0000000f);
		agent.send(mk(2'h1, switch_route_pkg::K_BCAST, 2'h0, 5'h0, 3'h0, 32'h0), 0);
		chk_out(1'b0, 4'h0);
	endtask

	task automatic t_sync();
		agent.send(mk(2'h0, switch_route_pkg::K_SYNC, 2'h0, 5'h0, 3'h0, 32'h0), 0);
		chk_ev(12'h00e);
		chk_st(2'h0, 32'h0);
		agent.send(mk(2'h2, switch_route_pkg::K_SYNC, 2'h0, 5'h0, 3'h0, 32'h0), 0);
		chk_ev(12'h004);
		chk_st(2'h2, 32'h80);
		reg_wr(8'h00, 32'h0000034f);
		reg_wr(8'h20, 32'h0000030f);
		agent.send(mk(2'h2, switch_route_pkg::K_SYNC, 2'h0, 5'h0, 3'h0, 32'h0), 1);
		chk_ev(12'h00f);
		chk_st(2'h2, 32'h88);
		chk_st(2'h0, 32'h88);
		reg_wr(8'h00, 32'h0000004f);
		reg_wr(8'h20, 32'h0000000f);
	endtask

	task automatic t_abort();
		round(2'h0, 2'h2, 1'b0, 1'b0, 1'b0);
		chk_st(2'h2, 32'h10);
		chk_st(2'h0, 32'h0);
		reg_wr(8'h20, 32'h0000008f);
		round(2'h0, 2'h2, 1'b0, 1'b1, 1'b1);
		chk_st(2'h2, 32'h14);
		chk_st(2'h0, 32'h24);
		reg_wr(8'h20, 32'h0000000f);
		round(2'h1, 2'h2, 1'b1, 1'b1, 1'b1);
		chk_st(2'h2, 32'h24);
		chk_st(2'h1, 32'h42);
		round(2'h2, 2'h2, 1'b0, 1'b1, 1'b0);
		chk_st(2'h2, 32'h0);
		round(2'h1, 2'h0, 1'b1, 1'b1, 1'b1);
		chk_st(2'h0, 32'h42);
		chk_st(2'h1, 32'h42);
		round(2'h1, 2'h0, 1'b0, 1'b0, 1'b0);
		chk_st(2'h0, 32'h1);
		reg_wr(8'h00, 32'h000000cf);
		round(2'h1, 2'h0, 1'b0, 1'b1, 1'b1);
		chk_st(2'h0, 32'h41);
		chk_st(2'h1, 32'h42);
		reg_wr(8'h00, 32'h0000004f);
	endtask

	task automatic t_drop();
		agent.send(mk(2'h1, switch_route_pkg::K_NPREQ, 2'h0, 5'h4, 3'h0, 32'h0), 0);
		agent.send(mk(2'h0, switch_route_pkg::K_RESP, 2'h0, agent.gotPkt.srcTag, 3'h0,
			32'h0), 0);
		chk_out(1'b0, 4'h0);
		chk_st(2'h0, 32'h100);
		agent.send(mk(2'h1, switch_route_pkg::K_RESP, 2'h0, 5'h0, 3'h4, 32'h0), 0);
		chk_out(1'b0, 4'h0);
		chk_st(2'h1, 32'h200);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		srst = 1'b1;
		regAddr = 8'h00;
		regWdata = 32'h0;
		regWr = 1'b0;
		regRd = 1'b0;
		errorCnt = 0;
		numChecks = 0;
		cycles = 0;
		repeat (3) @(posedge ref_clk);
		srst <= 1'b0;
		t_regs();
		t_table();
		t_reset();
		t_flush();
		t_bcast();
		t_sync();
		t_abort();
		t_drop();
		endSim();
	end
endmodule
